// ---- logic/ple_map.svh ----
`ifndef PLE_MAP_SVH
`define PLE_MAP_SVH

// link geometry
`define PLE_LANES            4
`define PLE_STAT_W           3
`define PLE_SEQ_W            12
`define PLE_RPLNUM_W         2

// per-lane receive status codes from the phy
`define PLE_RXST_DECODE_ERR  3'h4
`define PLE_RXST_EB_OVERFLOW 3'h5
`define PLE_RXST_EB_UNDERFL  3'h6
`define PLE_RXST_DISP_ERR    3'h7

// sequence space
`define PLE_SEQ_ONE          12'h001
`define PLE_SEQ_RESET        12'h000
`define PLE_SEQ_LAST_RESET   12'hfff
`define PLE_RPLNUM_MAX       2'h3

// timing
`define PLE_CLK_PERIOD_PS    5000
`define PLE_REPLAY_TMO_NS    10000
`define PLE_REPLAY_TMO_CYC   ((`PLE_REPLAY_TMO_NS * 1000) / `PLE_CLK_PERIOD_PS)
`define PLE_TMR_W            12

`endif

// ---- logic/ple_pkg.sv ----
package ple_pkg;

   // severity of a detected link error
   typedef enum logic [1:0] {
      PLE_SEV_NONE,
      PLE_SEV_CORRECTABLE,
      PLE_SEV_NONFATAL,
      PLE_SEV_FATAL
   } ple_sev_e;

   // replay timer state
   typedef enum logic {
      PLE_RPL_IDLE,
      PLE_RPL_RUN
   } ple_rpl_e;

   typedef logic [11:0] ple_seq_t;

endpackage

// ---- logic/ple_lane_check.sv ----
`timescale 1ns/1ps
`include "ple_map.svh"

module ple_lane_check (
   // clock, reset and enable
   input  wire logic                   i_clk,
   input  wire logic                   i_resetn,
   input  wire logic                   i_ce,
   // lane inputs
   input  wire logic [`PLE_STAT_W-1:0] i_rx_status,
   input  wire logic                   i_in_l0,
   input  wire logic                   i_ctrl_sym_wrong,
   // lane result
   output logic                        o_lane_err
);

   logic [`PLE_STAT_W-1:0] sync1;
   logic [`PLE_STAT_W-1:0] sync2;
   logic                   lane_err;
   logic [`PLE_STAT_W-1:0] next_sync1;
   logic [`PLE_STAT_W-1:0] next_sync2;
   logic                   next_lane_err;
   logic                   pcs_err;

   always_comb begin
      next_sync1 = i_rx_status;
      next_sync2 = sync1;
      // status comes from the phy clock domain, so only the second stage is decoded
      unique case (sync2)
         `PLE_RXST_DECODE_ERR,
         `PLE_RXST_DISP_ERR:    pcs_err = 1'b1;
         `PLE_RXST_EB_OVERFLOW,
         `PLE_RXST_EB_UNDERFL:  pcs_err = 1'b1;
         default:               pcs_err = 1'b0;
      endcase
      // coding errors outside l0 are expected during training and are ignored
      next_lane_err = (pcs_err && i_in_l0) || i_ctrl_sym_wrong;
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         sync1    <= 3'h0;
         sync2    <= 3'h0;
         lane_err <= 1'b0;
      end else if (i_ce) begin
         sync1    <= next_sync1;
         sync2    <= next_sync2;
         lane_err <= next_lane_err;
      end
   end

   assign o_lane_err = lane_err;

endmodule

// ---- logic/ple_link_error_detect.sv ----
`timescale 1ns/1ps
`include "ple_map.svh"

// Operation
// - report each error individually and also by severity class
// - correctable errors keep data intact; hardware recovers without software
// - non-fatal errors lose a packet but the fabric keeps working
// - receive port error from coding error, deskew overflow or misplaced symbol
// - per-lane 3-bit status counts as an error only while lane is in l0
// - status 100 decode error and 111 disparity error are receive port errors
// - status 101 and 110 elastic buffer over/underflow are receive port errors
// - deskew fifo overflow raises a receive port error
// - control symbol on a forbidden lane raises a receive port error
// - physical error reporting is optional; link works with it disabled
// - bad tlp on lcrc failure or unexpected sequence number
// - bad dllp on crc failure
// - correctable error each time the replay timer expires
// - correctable error when the replay count wraps past its maximum
// - fatal protocol error when ack/nak sequence matches neither an outstanding tlp nor the last acked one
module ple_link_error_detect (
   // clock, reset, enable
   input  wire logic                       i_clk,
   input  wire logic                       i_resetn,
   input  wire logic                       i_ce,
   // physical layer
   input  wire logic [`PLE_LANES*3-1:0]    i_rx_status,
   input  wire logic [`PLE_LANES-1:0]      i_lane_in_l0,
   input  wire logic                       i_deskew_overflow,
   input  wire logic [`PLE_LANES-1:0]      i_ctrl_sym_wrong_lane,
   input  wire logic                       i_phy_err_enable,
   // received packets
   input  wire logic                       i_tlp_valid,
   input  wire logic                       i_tlp_lcrc_ok,
   input  wire logic [`PLE_SEQ_W-1:0]      i_tlp_seq,
   input  wire logic                       i_dllp_valid,
   input  wire logic                       i_dllp_crc_ok,
   // transmit side
   input  wire logic                       i_tlp_sent,
   input  wire logic                       i_ack_valid,
   input  wire logic                       i_ack_is_nak,
   input  wire logic [`PLE_SEQ_W-1:0]      i_acknowledged_sequence_number,
   // individual error events
   output logic                            o_rx_port_err,
   output logic [`PLE_LANES-1:0]           o_lane_err,
   output logic                            o_bad_tlp,
   output logic                            o_bad_dllp,
   output logic                            o_replay_timeout,
   output logic                            o_replay_rollover,
   output logic                            o_dll_protocol_err,
   // severity events
   output logic                            o_err_correctable,
   output logic                            o_err_nonfatal,
   output logic                            o_err_fatal,
   // link state
   output logic                            o_replay_req,
   output logic [`PLE_SEQ_W-1:0]           o_expected_seq,
   output logic [`PLE_SEQ_W-1:0]           o_next_tx_seq
);

   localparam logic [`PLE_TMR_W-1:0] TMO_LAST = `PLE_TMR_W'(`PLE_REPLAY_TMO_CYC - 1);

   // ---------------- physical layer ----------------
   logic [`PLE_LANES-1:0] lane_err_raw;
   logic                  deskew_s1;
   logic                  deskew_s2;
   logic                  next_deskew_s1;
   logic                  next_deskew_s2;

   genvar g;
   generate
      for (g = 0; g < `PLE_LANES; g++) begin : g_lane
         ple_lane_check u_lane (
            .i_clk            (i_clk),
            .i_resetn         (i_resetn),
            .i_ce             (i_ce),
            .i_rx_status      (i_rx_status[g*3 +: 3]),
            .i_in_l0          (i_lane_in_l0[g]),
            .i_ctrl_sym_wrong (i_ctrl_sym_wrong_lane[g]),
            .o_lane_err       (lane_err_raw[g])
         );
      end
   endgenerate

   // same-clock flag: two stages and no synchroniser, so a deskew error
   // reports one cycle ahead of a coded lane error raised at the same edge
   always_comb begin
      next_deskew_s1 = i_deskew_overflow;
      next_deskew_s2 = deskew_s1;
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         deskew_s1 <= 1'b0;
         deskew_s2 <= 1'b0;
      end else if (i_ce) begin
         deskew_s1 <= next_deskew_s1;
         deskew_s2 <= next_deskew_s2;
      end
   end

   // ---------------- data link receive ----------------
   ple_pkg::ple_seq_t expected_seq;
   ple_pkg::ple_seq_t next_expected_seq;
   ple_pkg::ple_seq_t rx_gap;
   logic              rx_dup;
   logic              rx_seq_err;
   logic              bad_tlp_ev;
   logic              bad_dllp_ev;

   always_comb begin
      // a sequence up to 2048 behind the expected one is a harmless duplicate
      rx_gap            = expected_seq - `PLE_SEQ_ONE - i_tlp_seq;
      rx_dup            = ~rx_gap[`PLE_SEQ_W-1];
      rx_seq_err        = (i_tlp_seq != expected_seq) && !rx_dup;
      bad_tlp_ev        = i_tlp_valid && (!i_tlp_lcrc_ok || rx_seq_err);
      bad_dllp_ev       = i_dllp_valid && !i_dllp_crc_ok;
      next_expected_seq = expected_seq;
      if (i_tlp_valid && i_tlp_lcrc_ok && (i_tlp_seq == expected_seq)) begin
         next_expected_seq = expected_seq + `PLE_SEQ_ONE;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         expected_seq <= `PLE_SEQ_RESET;
      end else if (i_ce) begin
         expected_seq <= next_expected_seq;
      end
   end

   // ---------------- data link transmit / replay ----------------
   ple_pkg::ple_rpl_e              rpl_state;
   ple_pkg::ple_rpl_e              next_rpl_state;
   ple_pkg::ple_seq_t              next_tx_seq;
   ple_pkg::ple_seq_t              next_next_tx_seq;
   ple_pkg::ple_seq_t              acked_seq;
   ple_pkg::ple_seq_t              next_acked_seq;
   logic [`PLE_RPLNUM_W-1:0]       replay_num;
   logic [`PLE_RPLNUM_W-1:0]       next_replay_num;
   logic [`PLE_TMR_W-1:0]          timer;
   logic [`PLE_TMR_W-1:0]          next_timer;
   ple_pkg::ple_seq_t              last_tx;
   ple_pkg::ple_seq_t              ack_dist;
   ple_pkg::ple_seq_t              out_dist;
   logic                           ack_ok;
   logic                           progress;
   logic                           timeout_ev;
   logic                           replay_ev;
   logic                           rollover_ev;
   logic                           proto_ev;
   logic                           outstanding;

   always_comb begin
      last_tx  = next_tx_seq - `PLE_SEQ_ONE;
      ack_dist = last_tx - i_acknowledged_sequence_number;
      out_dist = last_tx - acked_seq;
      // an ack is legal only for a tlp between the last acked and last sent
      ack_ok   = ack_dist <= out_dist;
      proto_ev = i_ack_valid && !ack_ok;
      progress = i_ack_valid && ack_ok && (i_acknowledged_sequence_number != acked_seq);

      timeout_ev  = (rpl_state == ple_pkg::PLE_RPL_RUN) && (timer == TMO_LAST);
      replay_ev   = timeout_ev || (i_ack_valid && ack_ok && i_ack_is_nak);
      // a replay with forward progress restarts the count at one; only one without progress can wrap it
      rollover_ev = replay_ev && !progress && (replay_num == `PLE_RPLNUM_MAX);

      next_acked_seq   = progress ? i_acknowledged_sequence_number : acked_seq;
      next_next_tx_seq = i_tlp_sent ? next_tx_seq + `PLE_SEQ_ONE : next_tx_seq;

      next_replay_num = progress ? '0 : replay_num;
      if (replay_ev) begin
         next_replay_num = next_replay_num + 2'h1;
      end

      outstanding = (next_next_tx_seq - `PLE_SEQ_ONE) != next_acked_seq;
      next_timer  = timer;
      unique case (rpl_state)
         ple_pkg::PLE_RPL_IDLE: begin
            next_timer = '0;
         end
         ple_pkg::PLE_RPL_RUN: begin
            // progress or a replay restarts the full timeout
            if (progress || replay_ev) begin
               next_timer = '0;
            end else begin
               next_timer = timer + 12'h001;
            end
         end
      endcase
      next_rpl_state = outstanding ? ple_pkg::PLE_RPL_RUN : ple_pkg::PLE_RPL_IDLE;
      if (!outstanding) begin
         next_timer = '0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         rpl_state   <= ple_pkg::PLE_RPL_IDLE;
         next_tx_seq <= `PLE_SEQ_RESET;
         acked_seq   <= `PLE_SEQ_LAST_RESET;
         replay_num  <= '0;
         timer       <= '0;
      end else if (i_ce) begin
         rpl_state   <= next_rpl_state;
         next_tx_seq <= next_next_tx_seq;
         acked_seq   <= next_acked_seq;
         replay_num  <= next_replay_num;
         timer       <= next_timer;
      end
   end

   // ---------------- event outputs ----------------
   logic                  rx_port_err;
   logic [`PLE_LANES-1:0] lane_err;
   logic                  bad_tlp;
   logic                  bad_dllp;
   logic                  replay_timeout;
   logic                  replay_rollover;
   logic                  dll_protocol_err;
   logic                  err_corr;
   logic                  err_fatal;
   logic                  replay_req;
   logic                  next_rx_port_err;
   logic [`PLE_LANES-1:0] next_lane_err;
   logic                  next_err_corr;
   logic                  next_err_fatal;
   ple_pkg::ple_sev_e     dll_sev;

   always_comb begin
      // reporting off suppresses only the flags; lane checks keep running
      next_lane_err    = i_phy_err_enable ? lane_err_raw : '0;
      next_rx_port_err = i_phy_err_enable && ((|lane_err_raw) || deskew_s2);
      // class of this cycle's link-layer events, fatal dominating
      if (proto_ev) begin
         dll_sev = ple_pkg::PLE_SEV_FATAL;
      end else if (bad_tlp_ev || bad_dllp_ev || timeout_ev || rollover_ev) begin
         dll_sev = ple_pkg::PLE_SEV_CORRECTABLE;
      end else begin
         dll_sev = ple_pkg::PLE_SEV_NONE;
      end
      // correctable and fatal may both pulse; a fatal one never masks the other
      next_err_corr  = next_rx_port_err || bad_tlp_ev || bad_dllp_ev
                       || timeout_ev || rollover_ev;
      next_err_fatal = dll_sev == ple_pkg::PLE_SEV_FATAL;
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         rx_port_err      <= 1'b0;
         lane_err         <= '0;
         bad_tlp          <= 1'b0;
         bad_dllp         <= 1'b0;
         replay_timeout   <= 1'b0;
         replay_rollover  <= 1'b0;
         dll_protocol_err <= 1'b0;
         err_corr         <= 1'b0;
         err_fatal        <= 1'b0;
         replay_req       <= 1'b0;
      end else if (i_ce) begin
         rx_port_err      <= next_rx_port_err;
         lane_err         <= next_lane_err;
         bad_tlp          <= bad_tlp_ev;
         bad_dllp         <= bad_dllp_ev;
         replay_timeout   <= timeout_ev;
         replay_rollover  <= rollover_ev;
         dll_protocol_err <= proto_ev;
         err_corr         <= next_err_corr;
         err_fatal        <= next_err_fatal;
         replay_req       <= replay_ev && !rollover_ev;
      end else begin
         // a frozen cycle must not stretch a pulse
         rx_port_err      <= 1'b0;
         lane_err         <= '0;
         bad_tlp          <= 1'b0;
         bad_dllp         <= 1'b0;
         replay_timeout   <= 1'b0;
         replay_rollover  <= 1'b0;
         dll_protocol_err <= 1'b0;
         err_corr         <= 1'b0;
         err_fatal        <= 1'b0;
         replay_req       <= 1'b0;
      end
   end

   assign o_rx_port_err      = rx_port_err;
   assign o_lane_err         = lane_err;
   assign o_bad_tlp          = bad_tlp;
   assign o_bad_dllp         = bad_dllp;
   assign o_replay_timeout   = replay_timeout;
   assign o_replay_rollover  = replay_rollover;
   assign o_dll_protocol_err = dll_protocol_err;
   assign o_err_correctable  = err_corr;
   // no link-layer error is non-fatal; upper layers own that class
   assign o_err_nonfatal     = 1'b0;
   assign o_err_fatal        = err_fatal;
   assign o_replay_req       = replay_req;
   assign o_expected_seq     = expected_seq;
   assign o_next_tx_seq      = next_tx_seq;

endmodule

// ---- sim/ple_link_error_detect_monitor.sv ----
`timescale 1ns/1ps
`include "ple_map.svh"

module ple_link_error_detect_monitor (
   // clock, reset, enable
   input wire logic                    i_clk,
   input wire logic                    i_resetn,
   input wire logic                    i_ce,
   // watched inputs
   input wire logic [`PLE_LANES*3-1:0] i_rx_status,
   input wire logic [`PLE_LANES-1:0]   i_lane_in_l0,
   input wire logic                    i_deskew_overflow,
   input wire logic [`PLE_LANES-1:0]   i_ctrl_sym_wrong_lane,
   input wire logic                    i_phy_err_enable,
   input wire logic                    i_tlp_valid,
   input wire logic                    i_tlp_lcrc_ok,
   input wire logic                    i_dllp_valid,
   input wire logic                    i_dllp_crc_ok,
   // watched outputs
   input wire logic                    o_rx_port_err,
   input wire logic [`PLE_LANES-1:0]   o_lane_err,
   input wire logic                    o_bad_tlp,
   input wire logic                    o_bad_dllp,
   input wire logic                    o_replay_timeout,
   input wire logic                    o_replay_rollover,
   input wire logic                    o_dll_protocol_err,
   input wire logic                    o_err_correctable,
   input wire logic                    o_err_nonfatal,
   input wire logic                    o_err_fatal,
   input wire logic                    o_replay_req
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   // lane 0 code passes two sync stages, then the l0 check, then the enable gate
   property p_lane_code;
      (i_ce && i_rx_status[2] && i_phy_err_enable) ##1 i_ce ##1 (i_ce && i_lane_in_l0[0])
      ##1 (i_ce && i_phy_err_enable) |=> o_lane_err[0];
   endproperty
   a_lane_code: assert property (p_lane_code) else $error("lane code not reported");
   property p_deskew;
      (i_ce && i_deskew_overflow && i_phy_err_enable) ##1 i_ce
      ##1 (i_ce && i_phy_err_enable) |=> o_rx_port_err;
   endproperty
   a_deskew: assert property (p_deskew) else $error("deskew overflow lost");
   property p_ctrl;
      (i_ce && i_ctrl_sym_wrong_lane[2]) ##1 (i_ce && i_phy_err_enable)
      |=> o_lane_err[2] && o_rx_port_err;
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("misplaced symbol lost");
   property p_phy_off;
      !i_phy_err_enable |=> !o_rx_port_err && o_lane_err == 4'h0;
   endproperty
   a_phy_off: assert property (p_phy_off) else $error("phy error while disabled");
   property p_lcrc;
      i_ce && i_tlp_valid && !i_tlp_lcrc_ok |=> o_bad_tlp;
   endproperty
   a_lcrc: assert property (p_lcrc) else $error("lcrc failure not flagged");
   property p_dllp;
      i_ce |=> o_bad_dllp == ($past(i_dllp_valid) && !$past(i_dllp_crc_ok));
   endproperty
   a_dllp: assert property (p_dllp) else $error("bad dllp mismatch");
   property p_tmo;
      o_replay_timeout && !o_replay_rollover |-> o_replay_req ##1 !o_replay_timeout;
   endproperty
   a_tmo: assert property (p_tmo) else $error("timeout pulse wrong");
   property p_roll;
      o_replay_rollover |-> !o_replay_req && o_err_correctable;
   endproperty
   a_roll: assert property (p_roll) else $error("rollover requested replay");
   property p_sev;
      o_err_fatal == o_dll_protocol_err && !o_err_nonfatal && o_err_correctable ==
      (o_rx_port_err | o_bad_tlp | o_bad_dllp | o_replay_timeout | o_replay_rollover);
   endproperty
   a_sev: assert property (p_sev) else $error("severity class mismatch");
   property p_frozen;
      !i_ce |=> !o_err_correctable && !o_err_fatal;
   endproperty
   a_frozen: assert property (p_frozen) else $error("event while disabled");

   c_lane: cover property (o_lane_err[0]);
   c_fatal: cover property (o_err_fatal);
   c_roll: cover property (o_replay_rollover);
endmodule

// ---- sim/ple_phy_model.sv ----
`timescale 1ns/1ps
`include "ple_map.svh"

module ple_phy_model (
   // request from the bench
   input  wire logic                    i_send,
   input  wire logic [1:0]              i_lane,
   input  wire logic [2:0]              i_code,
   // pipe status toward the block
   output logic      [`PLE_LANES*3-1:0] o_rx_status
);
   // quiet lanes report 000; only the chosen lane carries a code
   always_comb begin
      o_rx_status = '0;
      if (i_send) begin
         o_rx_status[i_lane*3 +: 3] = i_code;
      end
   end
endmodule

// ---- sim/ple_link_error_detect_tb_top.sv ----
`timescale 1ns/1ps
`include "ple_map.svh"

module ple_link_error_detect_tb_top;
   typedef struct {logic [2:0] code; logic [1:0] ln; logic l0; logic exp;} ple_row_s;
   logic        i_clk = 1'b0, i_resetn = 1'b0, i_ce = 1'b1, i_phy_err_enable = 1'b1;
   logic [3:0]  i_lane_in_l0 = 4'hf, i_ctrl_sym_wrong_lane = 4'h0, o_lane_err;
   logic        i_deskew_overflow = 1'b0, i_tlp_valid = 1'b0, i_tlp_lcrc_ok = 1'b1;
   logic        i_dllp_valid = 1'b0, i_dllp_crc_ok = 1'b1, i_tlp_sent = 1'b0;
   logic        i_ack_valid = 1'b0, i_ack_is_nak = 1'b0, psend = 1'b0;
   logic [11:0] i_tlp_seq = 12'h000, i_acknowledged_sequence_number = 12'h000;
   logic [11:0] i_rx_status, o_expected_seq, o_next_tx_seq;
   logic [2:0]  pcode = 3'h0;
   logic [1:0]  plane = 2'h0;
   logic        o_rx_port_err, o_bad_tlp, o_bad_dllp, o_replay_timeout, o_replay_rollover;
   logic        o_dll_protocol_err, o_err_correctable, o_err_nonfatal, o_err_fatal;
   logic        o_replay_req;
   int          err_total = 0, checks = 0, cyc = 0;
   ple_row_s    rows [9] = '{'{3'h0, 2'h0, 1'h1, 1'h0}, '{3'h1, 2'h1, 1'h1, 1'h0},
      '{3'h2, 2'h2, 1'h1, 1'h0}, '{3'h3, 2'h3, 1'h1, 1'h0}, '{3'h4, 2'h0, 1'h1, 1'h1},
      '{3'h5, 2'h1, 1'h1, 1'h1}, '{3'h6, 2'h2, 1'h1, 1'h1}, '{3'h7, 2'h3, 1'h1, 1'h1},
      '{3'h4, 2'h1, 1'h0, 1'h0}};

   always #2.5 i_clk = ~i_clk;

   ple_phy_model phy_u (.i_send(psend), .i_lane(plane), .i_code(pcode), .o_rx_status(i_rx_status));
   ple_link_error_detect dut_u (.i_clk, .i_resetn, .i_ce, .i_rx_status, .i_lane_in_l0,
      .i_deskew_overflow, .i_ctrl_sym_wrong_lane, .i_phy_err_enable, .i_tlp_valid,
      .i_tlp_lcrc_ok, .i_tlp_seq, .i_dllp_valid, .i_dllp_crc_ok, .i_tlp_sent, .i_ack_valid,
      .i_ack_is_nak, .i_acknowledged_sequence_number, .o_rx_port_err, .o_lane_err, .o_bad_tlp,
      .o_bad_dllp, .o_replay_timeout, .o_replay_rollover, .o_dll_protocol_err,
      .o_err_correctable, .o_err_nonfatal, .o_err_fatal, .o_replay_req, .o_expected_seq,
      .o_next_tx_seq);

   task automatic chk_bit(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_seq(input string nm, input logic [11:0] e, input logic [11:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // one-cycle phy stimulus, then wait n-1 edges past the sampling edge
   task automatic phy(input logic [2:0] c, input logic [1:0] ln, input logic d,
                      input logic [3:0] cs, input int n);
      @(posedge i_clk);
      pcode <= c;
      plane <= ln;
      psend <= 1'b1;
      i_deskew_overflow <= d;
      i_ctrl_sym_wrong_lane <= cs;
      @(posedge i_clk);
      psend <= 1'b0;
      i_deskew_overflow <= 1'b0;
      i_ctrl_sym_wrong_lane <= 4'h0;
      repeat (n - 1) @(posedge i_clk);
      #1;
   endtask
   // drops the tlp, dllp, sent and ack strobes one edge after they were raised
   task automatic settle;
      @(posedge i_clk);
      {i_tlp_valid, i_dllp_valid, i_tlp_sent, i_ack_valid} <= 4'h0;
      #1;
   endtask
   task automatic tlp(input logic ok, input logic [11:0] s);
      @(posedge i_clk);
      i_tlp_valid <= 1'b1;
      i_tlp_lcrc_ok <= ok;
      i_tlp_seq <= s;
      settle;
   endtask
   task automatic ack(input logic n, input logic [11:0] s);
      @(posedge i_clk);
      i_ack_valid <= 1'b1;
      i_ack_is_nak <= n;
      i_acknowledged_sequence_number <= s;
      settle;
   endtask
   task automatic wait_tmo;
      for (int i = 0; i < 2100; i++) begin
         @(posedge i_clk);
         #1;
         if ((o_replay_timeout | o_replay_rollover) === 1'b1) begin
            break;
         end
      end
   endtask

   // the longest stretch is four replay timeouts of 2000 cycles each
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         end_of_test;
      end
   end

   initial begin
      repeat (2) @(posedge i_clk);
      i_resetn <= 1'b1;
      #1;
      chk_seq("expected_seq", 12'h000, o_expected_seq);
      chk_seq("next_tx_seq", 12'h000, o_next_tx_seq);
      repeat (2) @(posedge i_clk);
      foreach (rows[k]) begin
         @(posedge i_clk);
         i_lane_in_l0 <= rows[k].l0 ? 4'hf : ~(4'h1 << rows[k].ln);
         phy(rows[k].code, rows[k].ln, 1'b0, 4'h0, 4);
         chk_bit("lane_err", rows[k].exp, o_lane_err[rows[k].ln]);
         chk_bit("rx_port_err", rows[k].exp, o_rx_port_err);
         chk_bit("correctable", rows[k].exp, o_err_correctable);
      end
      phy(3'h0, 2'h0, 1'b1, 4'h0, 3);
      chk_bit("deskew rx_port_err", 1'b1, o_rx_port_err);
      chk_bit("deskew lane_err", 1'b0, |o_lane_err);
      phy(3'h0, 2'h0, 1'b0, 4'h4, 2);
      chk_bit("ctrl lane_err", 1'b1, o_lane_err[2]);
      chk_bit("ctrl rx_port_err", 1'b1, o_rx_port_err);
      @(posedge i_clk);
      i_phy_err_enable <= 1'b0;
      phy(3'h7, 2'h3, 1'b1, 4'h0, 4);
      chk_bit("disabled rx_port_err", 1'b0, o_rx_port_err);
      i_phy_err_enable <= 1'b1;
      tlp(1'b1, 12'h000);
      chk_seq("expected_seq", 12'h001, o_expected_seq);
      tlp(1'b1, 12'h005);
      chk_bit("seq bad_tlp", 1'b1, o_bad_tlp);
      tlp(1'b0, 12'h001);
      chk_bit("lcrc bad_tlp", 1'b1, o_bad_tlp);
      tlp(1'b1, 12'h000);
      chk_bit("duplicate bad_tlp", 1'b0, o_bad_tlp);
      chk_seq("expected_seq", 12'h001, o_expected_seq);
      for (int k = 0; k < 3; k++) begin
         @(posedge i_clk);
         i_ce <= (k != 2);
         i_dllp_valid <= 1'b1;
         i_dllp_crc_ok <= (k == 1);
         settle;
         chk_bit("bad_dllp", k == 0, o_bad_dllp);
      end
      i_ce <= 1'b1;
      @(posedge i_clk);
      i_tlp_sent <= 1'b1;
      settle;
      chk_seq("next_tx_seq", 12'h001, o_next_tx_seq);
      ack(1'b0, 12'h007);
      chk_bit("fatal", 1'b1, o_err_fatal);
      chk_bit("nonfatal", 1'b0, o_err_nonfatal);
      ack(1'b0, 12'h000);
      chk_bit("legal ack", 1'b0, o_dll_protocol_err);
      @(posedge i_clk);
      i_tlp_sent <= 1'b1;
      settle;
      for (int t = 1; t <= 4; t++) begin
         wait_tmo;
         chk_bit("replay_rollover", t == 4, o_replay_rollover);
         chk_bit("replay_req", t != 4, o_replay_req);
         chk_bit("correctable", 1'b1, o_err_correctable);
         chk_bit("replay_timeout", 1'b1, o_replay_timeout);
      end
      ack(1'b1, 12'h000);
      chk_bit("nak replay_req", 1'b1, o_replay_req);
      chk_bit("nak correctable", 1'b0, o_err_correctable);
      // reset must win over a low clock enable
      @(posedge i_clk);
      i_resetn <= 1'b0;
      i_ce <= 1'b0;
      @(posedge i_clk);
      i_resetn <= 1'b1;
      i_ce <= 1'b1;
      #1;
      chk_seq("reset expected_seq", 12'h000, o_expected_seq);
      chk_seq("reset next_tx_seq", 12'h000, o_next_tx_seq);
      end_of_test;
   end
endmodule

bind ple_link_error_detect ple_link_error_detect_monitor mon_u (.i_clk, .i_resetn, .i_ce,
   .i_rx_status, .i_lane_in_l0, .i_deskew_overflow, .i_ctrl_sym_wrong_lane, .i_phy_err_enable,
   .i_tlp_valid, .i_tlp_lcrc_ok, .i_dllp_valid, .i_dllp_crc_ok, .o_rx_port_err, .o_lane_err,
   .o_bad_tlp, .o_bad_dllp, .o_replay_timeout, .o_replay_rollover, .o_dll_protocol_err,
   .o_err_correctable, .o_err_nonfatal, .o_err_fatal, .o_replay_req);
